// ### dqtf_training.sv
// DQ training FIFO with pointer control, plus the DQS interval oscillator counter.
// Assumes decoded command pulses from the command path on clk_i, and that the
// write data path delivers one full burst per FIFO write after write latency.
module dqtf_training
    import dqtf_pkg::*;
#(
    parameter int DEPTH = DQTF_DEPTH,
    parameter int ENTRY_W = DQTF_ENTRY_W,
    parameter int BUF_DEPTH = DQTF_BUF_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Decoded commands, one-cycle pulses
    input wire logic mpc_i,
    input wire logic [6:0] mpc_op_i,
    input wire logic array_read_i,
    input wire logic pointer_clear_i,
    // Write burst arriving after write latency
    input wire logic wr_burst_valid_i,
    input wire logic [ENTRY_W-1:0] wr_burst_i,
    // Read burst toward the read latency pipe
    output logic rd_burst_valid_o,
    input wire logic rd_burst_ready_i,
    output logic [ENTRY_W-1:0] rd_burst_o,
    output logic cmd_stall_o,
    // Mode settings
    input wire logic wr_dbi_en_i,
    input wire logic rd_dbi_en_i,
    input wire logic dm_en_i,
    input wire logic [7:0] osc_run_time_i,
    // Ring oscillator pass pulse from the clock-tree replica, asynchronous
    input wire logic osc_pass_i,
    output logic osc_enable_o,
    output logic [7:0] osc_result_low_o,
    output logic [7:0] osc_result_high_o,
    output logic osc_result_valid_o,
    output logic dmi_drive_o,
    output logic [DQTF_PTR_W-1:0] wr_ptr_o,
    output logic [DQTF_PTR_W-1:0] rd_ptr_o
);
    logic [ENTRY_W-1:0] entry [DEPTH];
    logic [DQTF_PTR_W-1:0] wr_ptr;
    logic [DQTF_PTR_W-1:0] rd_ptr;
    logic [DQTF_PTR_W-1:0] fill_ptr;
    logic [DQTF_PTR_W:0] fill_pending;
    logic training_cmd;
    logic wr_fifo_cmd;
    logic rd_fifo_cmd;
    logic osc_start_cmd;
    logic osc_stop_cmd;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [ENTRY_W-1:0] buf_out_data;
    dqtf_osc_type osc_state;
    logic [DQTF_OSC_W-1:0] osc_count;
    logic [DQTF_OSC_W-1:0] run_left;
    logic [DQTF_OSC_W-1:0] run_target;
    logic auto_stop;
    logic run_done;
    logic pass_meta;
    logic pass_sync;
    logic pass_prev;
    logic pass_edge;

    // Operand bit six low makes the MPC a no-operation
    assign training_cmd = mpc_i && mpc_op_i[6];
    assign wr_fifo_cmd = training_cmd && (mpc_op_i == DQTF_OP_WR_FIFO);
    assign rd_fifo_cmd = training_cmd && (mpc_op_i == DQTF_OP_RD_FIFO);
    assign osc_start_cmd = training_cmd && (mpc_op_i == DQTF_OP_OSC_START);
    assign osc_stop_cmd = training_cmd && (mpc_op_i == DQTF_OP_OSC_STOP);

    // Modulo-five pointer step
    function automatic logic [DQTF_PTR_W-1:0] dqtf_step(input logic [DQTF_PTR_W-1:0] p);
        dqtf_step = (p == DQTF_PTR_LAST) ? DQTF_PTR_RESET : p + 1'b1;
    endfunction

    // Write pointer: FIFO writes and array reads advance it
    always_ff @(posedge clk_i) begin
        if (rst_i || pointer_clear_i) begin
            wr_ptr <= DQTF_PTR_RESET;
        end else if (wr_fifo_cmd || array_read_i) begin
            wr_ptr <= dqtf_step(wr_ptr);
        end
    end

    // Read pointer: FIFO reads and array reads advance it, wrapping after five
    always_ff @(posedge clk_i) begin
        if (rst_i || pointer_clear_i) begin
            rd_ptr <= DQTF_PTR_RESET;
        end else if (rd_fifo_cmd || array_read_i) begin
            rd_ptr <= dqtf_step(rd_ptr);
        end
    end

    // Slot for the write burst: captured at command time, used when data lands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fill_ptr <= DQTF_PTR_RESET;
            fill_pending <= '0;
        end else begin
            if (wr_fifo_cmd && fill_pending == '0) begin
                fill_ptr <= wr_ptr;
            end else if (wr_burst_valid_i && fill_pending != '0) begin
                fill_ptr <= dqtf_step(fill_ptr);
            end
            if (wr_fifo_cmd && !(wr_burst_valid_i && fill_pending != '0)) begin
                fill_pending <= fill_pending + 1'b1;
            end else if (!wr_fifo_cmd && wr_burst_valid_i && fill_pending != '0) begin
                fill_pending <= fill_pending - 1'b1;
            end
        end
    end

    // Entry storage; sixth write lands on the first slot, reads never modify
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            always_ff @(posedge clk_i) begin
                if (wr_burst_valid_i && fill_pending != '0 && fill_ptr == DQTF_PTR_W'(gi)) begin
                    entry[gi] <= wr_burst_i;
                end
            end
        end
    endgenerate

    // Read bursts queue toward the latency pipe; stall command path when full
    dqtf_stream_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(BUF_DEPTH)
    ) u_rd_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(rd_fifo_cmd),
        .in_ready_o(buf_in_ready),
        .in_data_i(entry[rd_ptr]),
        .out_valid_o(buf_out_valid),
        .out_ready_i(rd_burst_ready_i || !rd_burst_valid_o),
        .out_data_o(buf_out_data)
    );

    // Output register stage for read bursts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_burst_valid_o <= 1'b0;
            rd_burst_o <= '0;
        end else if (rd_burst_ready_i || !rd_burst_valid_o) begin
            rd_burst_valid_o <= buf_out_valid;
            rd_burst_o <= buf_out_data;
        end
    end

    // Back-pressure toward the command source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_stall_o <= 1'b0;
        end else begin
            cmd_stall_o <= !buf_in_ready;
        end
    end

    // DMI lanes driven when any of write DBI, read DBI or data mask is on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dmi_drive_o <= 1'b0;
        end else begin
            dmi_drive_o <= wr_dbi_en_i || rd_dbi_en_i || dm_en_i;
        end
    end

    // Pointer observation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_o <= DQTF_PTR_RESET;
            rd_ptr_o <= DQTF_PTR_RESET;
        end else begin
            wr_ptr_o <= wr_ptr;
            rd_ptr_o <= rd_ptr;
        end
    end

    // Synchronise the oscillator pass signal, then detect its rising edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pass_meta <= 1'b0;
            pass_sync <= 1'b0;
            pass_prev <= 1'b0;
        end else begin
            pass_meta <= osc_pass_i;
            pass_sync <= pass_meta;
            pass_prev <= pass_sync;
        end
    end
    assign pass_edge = pass_sync && !pass_prev;

    // Automatic stop only with a nonzero run-time setting
    assign auto_stop = (osc_run_time_i != DQTF_RUN_OFF);
    assign run_target = DQTF_OSC_W'(osc_run_time_i) * DQTF_OSC_W'(DQTF_RUN_SCALE);
    assign run_done = auto_stop && (run_left == DQTF_OSC_W'(1));

    // Oscillator run control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_state <= DQTF_OSC_IDLE;
            run_left <= DQTF_OSC_RESET;
        end else begin
            unique case (osc_state)
                DQTF_OSC_IDLE: begin
                    if (osc_start_cmd) begin
                        osc_state <= DQTF_OSC_RUN;
                        run_left <= run_target;
                    end
                end
                DQTF_OSC_RUN: begin
                    run_left <= run_left - 1'b1;
                    // Stop command is ignored while automatic stopping is set
                    if ((osc_stop_cmd && !auto_stop) || run_done) begin
                        osc_state <= DQTF_OSC_IDLE;
                    end
                end
            endcase
        end
    end

    // Pass counter, saturating at its maximum
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_count <= DQTF_OSC_RESET;
        end else if (osc_state == DQTF_OSC_IDLE && osc_start_cmd) begin
            osc_count <= DQTF_OSC_RESET;
        end else if (osc_state == DQTF_OSC_RUN && pass_edge && osc_count != DQTF_OSC_MAX) begin
            osc_count <= osc_count + 1'b1;
        end
    end

    // Enable for the ring oscillator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_enable_o <= 1'b0;
        end else begin
            osc_enable_o <= (osc_state == DQTF_OSC_RUN);
        end
    end

    // Store the result into low and high result bytes on any stop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_result_low_o <= 8'h00;
            osc_result_high_o <= 8'h00;
            osc_result_valid_o <= 1'b0;
        end else if (osc_state == DQTF_OSC_RUN && ((osc_stop_cmd && !auto_stop) || run_done)) begin
            osc_result_low_o <= osc_count[7:0];
            osc_result_high_o <= osc_count[15:8];
            osc_result_valid_o <= 1'b1;
        end else if (osc_start_cmd) begin
            osc_result_valid_o <= 1'b0;
        end
    end
endmodule // dqtf_training

// ### dqtf_pkg.sv
// Holds the shared constants of the DQ training FIFO and DQS oscillator block.
// Assumes the command decoder ahead of it delivers one-cycle command pulses on clk_i.
// How it works
// - Power-up, reset, power-down and self-refresh power-down entry clear both FIFO pointers.
// - FIFO write command advances write pointer; FIFO read command advances read pointer.
// - Ordinary array read advances both write and read pointers.
// - FIFO write accepted with banks open, during refresh, or self refresh with CKE high.
// - FIFO writes may come back to back; device takes each seamlessly.
// - FIFO write data uses normal write latency and termination timing.
// - FIFO holds five bursts; sixth write overwrites first; unwritten entries undefined.
// - FIFO reads may come back to back; device returns data seamlessly.
// - FIFO read data uses normal read latency timing.
// - FIFO reads do not alter contents; read pointer wraps after five.
// - Both DMI lanes driven in FIFO transfers when DBI or data mask enabled.
// - Start command starts ring oscillator counting passes through a clock-tree replica.
// - Oscillator stops on stop command or after the programmed run-time count.
// - On any stop the counter value is stored into the result registers.
// - Low result byte goes to the low register, high byte to the high one.
// - Oscillator counter saturates at maximum; controller discards a maximum result.
// - Automatic stopping is active only when the run-time field is nonzero.
// - MPC with operand bit six low is a no-operation.
package dqtf_pkg;
    localparam int DQTF_DEPTH = 5;
    localparam int DQTF_PTR_W = 3;
    localparam int DQTF_BURST = 16;
    localparam int DQTF_DQ_PINS = 16;
    localparam int DQTF_DMI_PINS = 2;
    localparam int DQTF_BEAT_W = DQTF_DQ_PINS + DQTF_DMI_PINS;
    localparam int DQTF_ENTRY_W = DQTF_BEAT_W * DQTF_BURST;
    localparam logic [2:0] DQTF_PTR_RESET = 3'h0;
    localparam logic [2:0] DQTF_PTR_LAST = 3'h4;
    localparam int DQTF_OSC_W = 16;
    localparam logic [15:0] DQTF_OSC_MAX = 16'hffff;
    localparam logic [15:0] DQTF_OSC_RESET = 16'h0000;
    localparam logic [7:0] DQTF_RUN_OFF = 8'h00;
    localparam int DQTF_RUN_SCALE = 16;
    localparam int DQTF_BUF_DEPTH = 4;
    // MPC training operand codes (bit 6 set selects training)
    localparam logic [6:0] DQTF_OP_WR_FIFO = 7'h47;
    localparam logic [6:0] DQTF_OP_RD_FIFO = 7'h41;
    localparam logic [6:0] DQTF_OP_OSC_START = 7'h4b;
    localparam logic [6:0] DQTF_OP_OSC_STOP = 7'h4d;
    typedef enum logic [1:0] {DQTF_OSC_IDLE, DQTF_OSC_RUN} dqtf_osc_type;
endpackage : dqtf_pkg

// ### dqtf_stream_fifo.sv
// Small valid/ready FIFO that decouples read-burst data from its consumer.
// Assumes both sides run on clk_i; push and pop in one cycle are allowed.
module dqtf_stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Handshake terms
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_idx];

    // Storage write
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_idx] <= in_data_i;
        end
    end

    // Index and occupancy tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
            end
            if (pop) begin
                rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // dqtf_stream_fifo

// ### dqtf_training_properties.sv
// Checker for the training block: pointer steps, clears, DMI drive and oscillator.
// Assumes a bind to dqtf_training; sees only its ports.
module dqtf_training_checker
    import dqtf_pkg::*;
#(
    parameter int ENTRY_W = DQTF_ENTRY_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mpc_i,
    input wire logic [6:0] mpc_op_i,
    input wire logic array_read_i,
    input wire logic pointer_clear_i,
    input wire logic rd_burst_valid_o,
    input wire logic rd_burst_ready_i,
    input wire logic [ENTRY_W-1:0] rd_burst_o,
    input wire logic wr_dbi_en_i,
    input wire logic rd_dbi_en_i,
    input wire logic dm_en_i,
    input wire logic [7:0] osc_run_time_i,
    input wire logic osc_enable_o,
    input wire logic osc_result_valid_o,
    input wire logic dmi_drive_o,
    input wire logic [DQTF_PTR_W-1:0] wr_ptr_o,
    input wire logic [DQTF_PTR_W-1:0] rd_ptr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] run_cnt;
    logic step;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Any command that may move a pointer
    assign step = (mpc_i && mpc_op_i[6]) || array_read_i || pointer_clear_i;
    // Cycles the oscillator has been running
    always_ff @(posedge clk_i) begin
        if (rst_i || !osc_enable_o) begin
            run_cnt <= 16'h0000;
        end else if (run_cnt != 16'hffff) begin
            run_cnt <= run_cnt + 16'h0001;
        end
    end
    property p_wr_step; mpc_i && mpc_op_i == DQTF_OP_WR_FIFO && !pointer_clear_i |-> ##[1:3] $changed(wr_ptr_o); endproperty
    a_wr_step: assert property (p_wr_step) else $error("write pointer did not step");
    property p_rd_step; mpc_i && mpc_op_i == DQTF_OP_RD_FIFO && !pointer_clear_i |-> ##[1:3] $changed(rd_ptr_o); endproperty
    a_rd_step: assert property (p_rd_step) else $error("read pointer did not step");
    property p_arr_step; array_read_i && !pointer_clear_i |-> ##[1:3] ($changed(wr_ptr_o) && $changed(rd_ptr_o)); endproperty
    a_arr_step: assert property (p_arr_step) else $error("array read left pointers");
    property p_wrap; $changed(rd_ptr_o) |-> rd_ptr_o == 3'h0 || rd_ptr_o == $past(rd_ptr_o) + 3'h1; endproperty
    a_wrap: assert property (p_wrap) else $error("read pointer jumped");
    property p_clear; pointer_clear_i |-> ##[1:3] (wr_ptr_o == 3'h0 && rd_ptr_o == 3'h0); endproperty
    a_clear: assert property (p_clear) else $error("pointers not cleared");
    property p_nop; !step [*3] |-> $stable(wr_ptr_o) && $stable(rd_ptr_o); endproperty
    a_nop: assert property (p_nop) else $error("pointer moved without command");
    property p_dmi; 1'b1 |=> dmi_drive_o == $past(wr_dbi_en_i || rd_dbi_en_i || dm_en_i); endproperty
    a_dmi: assert property (p_dmi) else $error("DMI drive wrong");
    property p_auto; osc_enable_o && osc_run_time_i != 8'h00 |-> run_cnt <= {4'h0, osc_run_time_i, 4'h0} + 16'h0002; endproperty
    a_auto: assert property (p_auto) else $error("oscillator overran its run time");
    property p_manual; mpc_i && mpc_op_i == DQTF_OP_OSC_STOP && osc_run_time_i == 8'h00 && osc_enable_o |-> ##[1:3] !osc_enable_o; endproperty
    a_manual: assert property (p_manual) else $error("stop not obeyed");
    property p_store; $fell(osc_enable_o) |-> ##[0:2] osc_result_valid_o; endproperty
    a_store: assert property (p_store) else $error("result not stored");
    property p_hold; rd_burst_valid_o && !rd_burst_ready_i |=> rd_burst_valid_o && $stable(rd_burst_o); endproperty
    a_hold: assert property (p_hold) else $error("read burst dropped while stalled");
endmodule // dqtf_training_checker

bind dqtf_training dqtf_training_checker #(.ENTRY_W(ENTRY_W)) chk (.clk_i(clk_i), .rst_i(rst_i), .mpc_i(mpc_i),
    .mpc_op_i(mpc_op_i), .array_read_i(array_read_i), .pointer_clear_i(pointer_clear_i),
    .rd_burst_valid_o(rd_burst_valid_o), .rd_burst_ready_i(rd_burst_ready_i), .rd_burst_o(rd_burst_o),
    .wr_dbi_en_i(wr_dbi_en_i), .rd_dbi_en_i(rd_dbi_en_i), .dm_en_i(dm_en_i), .osc_run_time_i(osc_run_time_i),
    .osc_enable_o(osc_enable_o), .osc_result_valid_o(osc_result_valid_o), .dmi_drive_o(dmi_drive_o),
    .wr_ptr_o(wr_ptr_o), .rd_ptr_o(rd_ptr_o));

// ### dqtf_ctrl_model.sv
// Controller-side model: takes read bursts and drives the oscillator replica.
// Assumes one clock; stall_i comes from the testbench.
module dqtf_ctrl_model
    import dqtf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic rd_burst_valid_i,
    input wire logic [DQTF_ENTRY_W-1:0] rd_burst_i,
    output logic rd_burst_ready_o,
    input wire logic osc_enable_i,
    output logic osc_pass_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DQTF_ENTRY_W-1:0] got[$];
    initial begin
        rd_burst_ready_o = 1'b0;
        osc_pass_o = 1'b0;
    end
    // Takes a burst every cycle unless stalled, and keeps it
    always @(posedge clk_i) begin
        rd_burst_ready_o <= !stall_i && !rst_i;
        if (rd_burst_valid_i && rd_burst_ready_o) begin
            got.push_back(rd_burst_i);
        end
    end
    // Pass edge every two cycles while running, still otherwise
    always @(posedge clk_i) begin
        osc_pass_o <= osc_enable_i && !osc_pass_o;
    end
endmodule // dqtf_ctrl_model

// ### testbench.sv
// Self-checking bench: FIFO writes and reads, read buffer, DMI drive, oscillator.
// Assumes the design, its checker bind and the controller model are compiled first.
module testbench
    import dqtf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, mpc_i, array_read_i, pointer_clear_i, wr_burst_valid_i, stall;
    logic wr_dbi_en_i, rd_dbi_en_i, dm_en_i;
    logic [6:0] mpc_op_i;
    logic [7:0] osc_run_time_i;
    logic [DQTF_ENTRY_W-1:0] wr_burst_i, rd_burst_o;
    logic [DQTF_ENTRY_W-1:0] e[5];
    logic rd_burst_valid_o, rd_burst_ready_i, cmd_stall_o, osc_pass_i, osc_enable_o, osc_result_valid_o, dmi_drive_o;
    logic [7:0] lo, hi;
    logic [2:0] wr_ptr_o, rd_ptr_o;
    int failures, check_count, n, cyc;
    dqtf_training uut (.clk_i(clk_i), .rst_i(rst_i), .mpc_i(mpc_i), .mpc_op_i(mpc_op_i), .array_read_i(array_read_i),
        .pointer_clear_i(pointer_clear_i), .wr_burst_valid_i(wr_burst_valid_i), .wr_burst_i(wr_burst_i),
        .rd_burst_valid_o(rd_burst_valid_o), .rd_burst_ready_i(rd_burst_ready_i), .rd_burst_o(rd_burst_o),
        .cmd_stall_o(cmd_stall_o), .wr_dbi_en_i(wr_dbi_en_i), .rd_dbi_en_i(rd_dbi_en_i), .dm_en_i(dm_en_i),
        .osc_run_time_i(osc_run_time_i), .osc_pass_i(osc_pass_i), .osc_enable_o(osc_enable_o),
        .osc_result_low_o(lo), .osc_result_high_o(hi), .osc_result_valid_o(osc_result_valid_o),
        .dmi_drive_o(dmi_drive_o), .wr_ptr_o(wr_ptr_o), .rd_ptr_o(rd_ptr_o));
    dqtf_ctrl_model mdl (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .rd_burst_valid_i(rd_burst_valid_o),
        .rd_burst_i(rd_burst_o), .rd_burst_ready_o(rd_burst_ready_i), .osc_enable_i(osc_enable_o),
        .osc_pass_o(osc_pass_i));
    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic check(input string what, input logic [DQTF_ENTRY_W-1:0] seen, input logic [DQTF_ENTRY_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One command on the next falling edge, left up for back-to-back use; CAS-2 operands stay low
    task automatic cmd(input logic [6:0] op, input logic ar);
        @(negedge clk_i);
        mpc_i = !ar;
        mpc_op_i = op;
        array_read_i = ar;
    endtask
    task automatic idle(input int k);
        @(negedge clk_i);
        {mpc_i, array_read_i, pointer_clear_i, wr_burst_valid_i} = 4'h0;
        repeat (k) @(negedge clk_i);
    endtask
    task automatic do_reset();
        rst_i = 1'b1;
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
    endtask
    function automatic logic [DQTF_ENTRY_W-1:0] pat(input int i);
        return {18{i[15:0] ^ 16'h5a3c}};
    endfunction
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        conclude();
    end
    initial begin
        {mpc_i, array_read_i, pointer_clear_i, wr_burst_valid_i, stall, wr_dbi_en_i, rd_dbi_en_i, dm_en_i} = 8'h00;
        mpc_op_i = 7'h00;
        osc_run_time_i = 8'h00;
        wr_burst_i = '0;
        do_reset();
        idle(1);
        check("reset pointers", {wr_ptr_o, rd_ptr_o, osc_enable_o, cmd_stall_o}, 0);
        // Six back-to-back writes, then reads with nothing in between
        for (int i = 0; i < 6; i++) cmd(DQTF_OP_WR_FIFO, 1'b0);
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_i);
            mpc_i = 1'b0;
            wr_burst_valid_i = 1'b1;
            wr_burst_i = pat(i);
            e[i % 5] = pat(i);
        end
        idle(3);
        check("wr_ptr after six", wr_ptr_o, 3'h1);
        for (int i = 0; i < 6; i++) cmd(DQTF_OP_RD_FIFO, 1'b0);
        idle(12);
        check("read count", mdl.got.size(), 6);
        for (int k = 0; k < 6; k++) check("read data", mdl.got[k], e[k % 5]);
        check("rd_ptr wrap", rd_ptr_o, 3'h1);
        mdl.got.delete();
        cmd(7'h00, 1'b1);
        idle(3);
        check("array read ptrs", {wr_ptr_o, rd_ptr_o}, 6'h12);
        cmd(DQTF_OP_WR_FIFO & 7'h3f, 1'b0);
        idle(3);
        check("nop ptrs", {wr_ptr_o, rd_ptr_o}, 6'h12);
        // Fill the read buffer while the controller stalls, then drain it
        stall = 1'b1;
        n = 0;
        while (cmd_stall_o !== 1'b1 && n < 12) begin
            cmd(DQTF_OP_RD_FIFO, 1'b0);
            idle(2);
            n++;
        end
        check("buffer full", {cmd_stall_o, n >= 4}, 2'h3);
        stall = 1'b0;
        idle(20);
        check("drain count", mdl.got.size(), n);
        for (int k = 0; k < n; k++) check("drain data", mdl.got[k], e[(2 + k) % 5]);
        check("drained", cmd_stall_o, 1'b0);
        mdl.got.delete();
        @(negedge clk_i);
        pointer_clear_i = 1'b1;
        idle(3);
        check("cleared ptrs", {wr_ptr_o, rd_ptr_o}, 0);
        cmd(DQTF_OP_WR_FIFO, 1'b0);
        idle(1);
        do_reset();
        idle(1);
        check("reset mid-run", {wr_ptr_o, rd_ptr_o}, 0);
        for (int m = 0; m < 8; m++) begin
            @(negedge clk_i);
            {wr_dbi_en_i, rd_dbi_en_i, dm_en_i} = m[2:0];
            idle(2);
            check("dmi drive", dmi_drive_o, |m[2:0]);
        end
        // Manual oscillator run of about 600 cycles
        cmd(DQTF_OP_OSC_START, 1'b0);
        idle(600);
        check("still running", osc_enable_o, 1'b1);
        cmd(DQTF_OP_OSC_STOP, 1'b0);
        idle(5);
        check("manual stop", {osc_enable_o, osc_result_valid_o}, 2'h1);
        check("manual count", {hi, lo} >= 16'h0128 && {hi, lo} <= 16'h0130, 1'b1);
        // Timed run of 32 cycles; a stop in mid-run is refused
        osc_run_time_i = 8'h02;
        cmd(DQTF_OP_OSC_START, 1'b0);
        idle(1);
        check("valid clears", osc_result_valid_o, 1'b0);
        cyc = 0;
        while (osc_enable_o === 1'b1 && cyc < 100) begin
            @(negedge clk_i);
            cyc++;
            mpc_i = (cyc == 5);
            mpc_op_i = DQTF_OP_OSC_STOP;
        end
        idle(2);
        check("timed length", cyc >= 30 && cyc <= 34, 1'b1);
        check("timed result", osc_result_valid_o && {hi, lo} >= 16'h000c && {hi, lo} <= 16'h0014, 1'b1);
        conclude();
    end
endmodule // testbench
